/* dtdec_decode.sv */
// Combinational opcode decode with operand-field check and minimum clocks.
// Assumes the first two queue bytes are presented; pure logic.
`default_nettype none
module dtdec_decode (
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] modrm_i,
    input wire logic narrow_i,
    input wire logic word_i,
    output dtdec_pkg::dtdec_op_e op_o,
    output logic needs_modrm_o,
    output logic legal_o,
    output logic mem_o,
    output logic [5:0] clocks_o
);
    logic reg_mode;
    logic [5:0] base;
    assign reg_mode = modrm_i[dtdec_pkg::MODE_MSB:dtdec_pkg::MODE_LSB] == dtdec_pkg::MODE_REGISTER;

    function automatic logic [5:0] pick(input logic nar, input logic [5:0] w,
                                        input logic [5:0] n);
        pick = nar ? n : w;
    endfunction

    always_comb begin
        op_o = dtdec_pkg::DTDEC_NONE;
        needs_modrm_o = 1'b0;
        legal_o = 1'b1;
        mem_o = 1'b0;
        base = dtdec_pkg::CLK_ONE;
        case (opcode_i)
            dtdec_pkg::OP_SEG_LOAD: begin
                op_o = dtdec_pkg::DTDEC_SEG_LOAD;
                needs_modrm_o = 1'b1;
                mem_o = !reg_mode;
                base = reg_mode ? dtdec_pkg::CLK_SEG_LOAD_REG :
                    pick(narrow_i, dtdec_pkg::CLK_SEG_LOAD_MEM_W, dtdec_pkg::CLK_SEG_LOAD_MEM_N);
            end
            dtdec_pkg::OP_SEG_STORE: begin
                op_o = dtdec_pkg::DTDEC_SEG_STORE;
                needs_modrm_o = 1'b1;
                mem_o = !reg_mode;
                base = reg_mode ? dtdec_pkg::CLK_SEG_STORE_REG :
                    pick(narrow_i, dtdec_pkg::CLK_SEG_STORE_MEM_W,
                         dtdec_pkg::CLK_SEG_STORE_MEM_N);
            end
            dtdec_pkg::OP_TABLE_LOOKUP: begin
                op_o = dtdec_pkg::DTDEC_TABLE_LOOKUP;
                mem_o = 1'b1;
                base = pick(narrow_i, dtdec_pkg::CLK_LOOKUP_W, dtdec_pkg::CLK_LOOKUP_N);
            end
            dtdec_pkg::OP_EA_LOAD: begin
                op_o = dtdec_pkg::DTDEC_EA_LOAD;
                needs_modrm_o = 1'b1;
                base = dtdec_pkg::CLK_EA_LOAD;
            end
            dtdec_pkg::OP_FAR_DATA_SEG, dtdec_pkg::OP_FAR_EXTRA_SEG: begin
                op_o = (opcode_i == dtdec_pkg::OP_FAR_DATA_SEG) ?
                    dtdec_pkg::DTDEC_FAR_DATA_SEG : dtdec_pkg::DTDEC_FAR_EXTRA_SEG;
                needs_modrm_o = 1'b1;
                legal_o = !reg_mode;
                mem_o = 1'b1;
                base = pick(narrow_i, dtdec_pkg::CLK_FAR_W, dtdec_pkg::CLK_FAR_N);
            end
            dtdec_pkg::OP_FLAGS_TO_ACC: begin
                op_o = dtdec_pkg::DTDEC_FLAGS_TO_ACC;
                base = dtdec_pkg::CLK_FLAGS_TO_ACC;
            end
            dtdec_pkg::OP_ACC_TO_FLAGS: begin
                op_o = dtdec_pkg::DTDEC_ACC_TO_FLAGS;
                base = dtdec_pkg::CLK_ACC_TO_FLAGS;
            end
            default: begin
                legal_o = 1'b0;
            end
        endcase
        // Seg moves are not starred; only a word table lookup on the narrow bus pays extra
        clocks_o = base;
        if (narrow_i && word_i && mem_o && (op_o == dtdec_pkg::DTDEC_TABLE_LOOKUP)) begin
            clocks_o = base + dtdec_pkg::CLK_WORD_PER_XFER;
        end
    end
endmodule
`default_nettype wire

/* dtdec_feeder.sv */
// Prefetch bus unit model: offers a byte string to the queue, one byte a handshake.
// Assumes the caller pulses start_i for one clock with the string and count held.
`default_nettype none
module dtdec_feeder (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [3:0] nbytes_i,
    input wire logic [95:0] bytes_i,
    input wire logic slow_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] byte_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [95:0] data;
    int n;
    int guard;
    initial begin
        valid_o = 1'b0;
        byte_o = 8'h00;
    end
    always begin
        @(posedge clk_i iff start_i);
        data = bytes_i;
        n = int'(nbytes_i);
        for (int i = 0; i < n; i++) begin
            // Slow mode starves the queue between bytes
            if (slow_i) begin
                repeat (3) @(posedge clk_i);
            end
            @(negedge clk_i);
            valid_o = 1'b1;
            byte_o = data[8*i +: 8];
            guard = 0;
            do begin
                @(posedge clk_i);
                guard++;
            end while (!ready_i && guard < 400);
            @(negedge clk_i);
            // Released line shows the inverse, never a stale copy
            valid_o = 1'b0;
            byte_o = ~byte_o;
        end
    end
endmodule
`default_nettype wire

/* dtdec_pkg.sv */
// Constants for the data-transfer decode and timing block.
// Assumes a single processor clock; no software-visible registers.
package dtdec_pkg;
    localparam logic [7:0] OP_SEG_LOAD = 8'h8E;
    localparam logic [7:0] OP_SEG_STORE = 8'h8C;
    localparam logic [7:0] OP_TABLE_LOOKUP = 8'hD7;
    localparam logic [7:0] OP_EA_LOAD = 8'h8D;
    localparam logic [7:0] OP_FAR_DATA_SEG = 8'hC5;
    localparam logic [7:0] OP_FAR_EXTRA_SEG = 8'hC4;
    localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h9F;
    localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h9E;
    localparam logic [1:0] MODE_REGISTER = 2'h3;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int QUEUE_DEPTH_WIDE = 6;
    localparam int QUEUE_DEPTH_NARROW = 4;
    localparam logic [5:0] CLK_SEG_LOAD_REG = 6'h02;
    localparam logic [5:0] CLK_SEG_LOAD_MEM_W = 6'h09;
    localparam logic [5:0] CLK_SEG_LOAD_MEM_N = 6'h0D;
    localparam logic [5:0] CLK_SEG_STORE_REG = 6'h02;
    localparam logic [5:0] CLK_SEG_STORE_MEM_W = 6'h0B;
    localparam logic [5:0] CLK_SEG_STORE_MEM_N = 6'h0F;
    localparam logic [5:0] CLK_LOOKUP_W = 6'h0B;
    localparam logic [5:0] CLK_LOOKUP_N = 6'h0F;
    localparam logic [5:0] CLK_EA_LOAD = 6'h06;
    localparam logic [5:0] CLK_FAR_W = 6'h12;
    localparam logic [5:0] CLK_FAR_N = 6'h1A;
    localparam logic [5:0] CLK_FLAGS_TO_ACC = 6'h02;
    localparam logic [5:0] CLK_ACC_TO_FLAGS = 6'h03;
    localparam logic [5:0] CLK_WORD_PER_XFER = 6'h04;
    localparam logic [5:0] CLK_ONE = 6'h01;
    typedef enum logic [3:0] {
        DTDEC_NONE = 4'h0,
        DTDEC_SEG_LOAD = 4'h1,
        DTDEC_SEG_STORE = 4'h2,
        DTDEC_TABLE_LOOKUP = 4'h3,
        DTDEC_EA_LOAD = 4'h4,
        DTDEC_FAR_DATA_SEG = 4'h5,
        DTDEC_FAR_EXTRA_SEG = 4'h6,
        DTDEC_FLAGS_TO_ACC = 4'h7,
        DTDEC_ACC_TO_FLAGS = 4'h8
    } dtdec_op_e;
    typedef enum logic [1:0] {
        DTDEC_IDLE = 2'b00,
        DTDEC_FETCH = 2'b01,
        DTDEC_EXEC = 2'b10,
        DTDEC_DONE = 2'b11
    } dtdec_state_e;
endpackage

/* dtdec_queue.sv */
// Instruction prefetch queue, bytes in from the prefetch bus unit.
// Assumes the filler obeys in_ready and the drain pops only what is held.
`default_nettype none
module dtdec_queue #(
    parameter int DEPTH = 6
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    input wire logic [7:0] in_byte_i,
    output logic in_ready_o,
    input wire logic [1:0] pop_i,
    output logic [7:0] head0_o,
    output logic [7:0] head1_o,
    output logic [3:0] count_o
);
    logic [7:0] mem_ff [DEPTH];
    logic [3:0] count_ff;
    logic [3:0] nxt_count;
    logic push;
    logic [3:0] pop_n;

    assign in_ready_o = count_ff < 4'(DEPTH);
    assign push = in_valid_i && in_ready_o;
    assign pop_n = (4'(pop_i) > count_ff) ? count_ff : 4'(pop_i);
    assign nxt_count = count_ff - pop_n + (push ? 4'h1 : 4'h0);
    assign count_o = count_ff;
    assign head0_o = mem_ff[0];
    assign head1_o = mem_ff[1];

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_ff <= 4'h0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Shift register: depth is tiny, so shifting beats pointer bookkeeping
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && (4'(i) == count_ff - pop_n)) begin
                    mem_ff[i] <= in_byte_i;
                end else if (i + int'(pop_n) < DEPTH) begin
                    mem_ff[i] <= mem_ff[i + int'(pop_n)];
                end
            end
        end
    end

    a_queue_never_over: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        count_ff <= 4'(DEPTH)) else $error("queue over depth");
endmodule
`default_nettype wire

/* dtdec_top.sv */
// Data-transfer decode and minimum-clock sequencer with its prefetch queue.
// Assumes bytes arrive from the prefetch bus unit synchronous to CORE_CLK_I.
`default_nettype none
module dtdec_top #(
    parameter bit NARROW_BUS = 1'b0,
    parameter int QDEPTH = NARROW_BUS ? dtdec_pkg::QUEUE_DEPTH_NARROW :
                                        dtdec_pkg::QUEUE_DEPTH_WIDE
) (
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire logic FETCH_VALID_I,
    input wire logic [7:0] FETCH_BYTE_I,
    output logic FETCH_READY_O,
    input wire logic WORD_OP_I,
    input wire logic MEM_WAIT_I,
    output logic [3:0] OP_O,
    output logic BUSY_O,
    output logic DONE_O,
    output logic ILLEGAL_O,
    output logic [7:0] MODRM_O,
    output logic [5:0] CLOCKS_O
);
    dtdec_pkg::dtdec_state_e state_ff;
    dtdec_pkg::dtdec_state_e nxt_state;
    logic [7:0] head0;
    logic [7:0] head1;
    logic [3:0] qcount;
    logic [1:0] pop;
    logic in_ready;
    dtdec_pkg::dtdec_op_e dec_op;
    logic dec_modrm;
    logic dec_legal;
    logic dec_mem;
    logic [5:0] dec_clocks;
    logic have_bytes;
    logic [5:0] cnt_ff;
    logic [1:0] extra_ff;
    logic mem_ff;
    logic [5:0] spent_ff;
    logic [3:0] op_ff;
    logic busy_ff;
    logic done_ff;
    logic illegal_ff;
    logic [7:0] modrm_ff;
    logic [5:0] clocks_ff;
    logic ready_ff;
    logic [3:0] nxt_fill;

    // Queue depth follows the bus width variant
    dtdec_queue #(.DEPTH(QDEPTH)) u_queue (
        .core_clk_i(CORE_CLK_I),
        .nrst_i(NRST_I),
        .in_valid_i(FETCH_VALID_I),
        .in_byte_i(FETCH_BYTE_I),
        .in_ready_o(in_ready),
        .pop_i(pop),
        .head0_o(head0),
        .head1_o(head1),
        .count_o(qcount)
    );

    dtdec_decode u_decode (
        .opcode_i(head0),
        .modrm_i(head1),
        .narrow_i(NARROW_BUS),
        .word_i(WORD_OP_I),
        .op_o(dec_op),
        .needs_modrm_o(dec_modrm),
        .legal_o(dec_legal),
        .mem_o(dec_mem),
        .clocks_o(dec_clocks)
    );

    // Decode waits until the opcode and any modrm byte sit in the queue
    assign have_bytes = dec_modrm ? (qcount >= 4'h2) : (qcount >= 4'h1);
    assign pop = (state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes) ?
                 (dec_modrm ? 2'h2 : 2'h1) : 2'h0;
    // Fill level after this edge, so ready never promises a slot already taken
    assign nxt_fill = qcount - 4'(pop) + ((FETCH_VALID_I && in_ready) ? 4'h1 : 4'h0);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            dtdec_pkg::DTDEC_IDLE: begin
                nxt_state = dtdec_pkg::DTDEC_FETCH;
            end
            dtdec_pkg::DTDEC_FETCH: begin
                if (have_bytes) begin
                    nxt_state = dec_legal ? dtdec_pkg::DTDEC_EXEC : dtdec_pkg::DTDEC_DONE;
                end
            end
            dtdec_pkg::DTDEC_EXEC: begin
                if (cnt_ff == dtdec_pkg::CLK_ONE && extra_ff == 2'h0) begin
                    nxt_state = dtdec_pkg::DTDEC_DONE;
                end
            end
            dtdec_pkg::DTDEC_DONE: begin
                nxt_state = dtdec_pkg::DTDEC_FETCH;
            end
            default: begin
                nxt_state = dtdec_pkg::DTDEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_ff <= dtdec_pkg::DTDEC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Minimum count runs down first, then the handshake slack
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cnt_ff <= 6'h00;
            extra_ff <= 2'h0;
            mem_ff <= 1'b0;
        end else if (state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes) begin
            cnt_ff <= dec_clocks;
            extra_ff <= 2'h0;
            mem_ff <= dec_mem;
        end else if (state_ff == dtdec_pkg::DTDEC_EXEC) begin
            if (cnt_ff > dtdec_pkg::CLK_ONE) begin
                cnt_ff <= cnt_ff - dtdec_pkg::CLK_ONE;
                if (mem_ff && MEM_WAIT_I && extra_ff == 2'h0) begin
                    extra_ff <= 2'h2;
                end
            end else if (extra_ff != 2'h0) begin
                extra_ff <= extra_ff - 2'h1;
            end else if (mem_ff && MEM_WAIT_I) begin
                extra_ff <= 2'h1;
                mem_ff <= 1'b0;
            end
        end
    end

    // Cycles actually spent in execution, used by the checks
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            spent_ff <= 6'h00;
        end else if (state_ff == dtdec_pkg::DTDEC_FETCH) begin
            spent_ff <= 6'h00;
        end else if (state_ff == dtdec_pkg::DTDEC_EXEC) begin
            spent_ff <= spent_ff + dtdec_pkg::CLK_ONE;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            op_ff <= 4'h0;
            illegal_ff <= 1'b0;
            modrm_ff <= 8'h00;
            clocks_ff <= 6'h00;
        end else if (state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes) begin
            op_ff <= 4'(dec_op);
            illegal_ff <= !dec_legal;
            modrm_ff <= dec_modrm ? head1 : 8'h00;
            clocks_ff <= dec_clocks;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_state == dtdec_pkg::DTDEC_EXEC;
            done_ff <= nxt_state == dtdec_pkg::DTDEC_DONE;
            ready_ff <= nxt_fill < 4'(QDEPTH);
        end
    end

    // Ready is registered from the next fill level; excess pushes are dropped
    assign FETCH_READY_O = ready_ff;
    assign OP_O = op_ff;
    assign BUSY_O = busy_ff;
    assign DONE_O = done_ff;
    assign ILLEGAL_O = illegal_ff;
    assign MODRM_O = modrm_ff;
    assign CLOCKS_O = clocks_ff;

    a_exec_min_count: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        $rose(done_ff) && !illegal_ff |-> spent_ff >= clocks_ff)
        else $error("finished before minimum count");
    a_exec_extra_bound: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        $rose(done_ff) && !illegal_ff |-> spent_ff <= clocks_ff + 6'h02)
        else $error("more than two extra clocks");
    a_far_reg_bad: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes && head0[7:1] == 7'h62 &&
        head1[7:6] == dtdec_pkg::MODE_REGISTER |=> illegal_ff ##1 !busy_ff)
        else $error("register mode far pointer accepted");
    a_lookup_count: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes &&
        head0 == dtdec_pkg::OP_TABLE_LOOKUP && !WORD_OP_I |=>
        clocks_ff == (NARROW_BUS ? dtdec_pkg::CLK_LOOKUP_N : dtdec_pkg::CLK_LOOKUP_W))
        else $error("lookup count wrong");
    a_seg_load_pair: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes &&
        head0 == dtdec_pkg::OP_SEG_LOAD |=> clocks_ff == ($past(head1[7:6]) == 2'h3 ?
        dtdec_pkg::CLK_SEG_LOAD_REG : (NARROW_BUS ? dtdec_pkg::CLK_SEG_LOAD_MEM_N :
        dtdec_pkg::CLK_SEG_LOAD_MEM_W)))
        else $error("segment load count wrong");
    a_seg_store_pair: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes &&
        head0 == dtdec_pkg::OP_SEG_STORE && head1[7:6] != 2'h3 |=>
        clocks_ff == (NARROW_BUS ? dtdec_pkg::CLK_SEG_STORE_MEM_N :
        dtdec_pkg::CLK_SEG_STORE_MEM_W))
        else $error("segment store count wrong");
    a_flags_counts: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes && head0[7:1] == 7'h4F |=>
        clocks_ff == ($past(head0[0]) ? dtdec_pkg::CLK_FLAGS_TO_ACC :
        dtdec_pkg::CLK_ACC_TO_FLAGS))
        else $error("flags transfer count wrong");
    a_ea_load_six: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes && head0 == dtdec_pkg::OP_EA_LOAD
        |=> clocks_ff == dtdec_pkg::CLK_EA_LOAD ##[1:7] done_ff)
        else $error("address load count wrong");
    a_far_count: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes && head0[7:1] == 7'h62 |=>
        clocks_ff == (NARROW_BUS ? dtdec_pkg::CLK_FAR_N : dtdec_pkg::CLK_FAR_W))
        else $error("far pointer count wrong");
    a_word_lookup_add: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        state_ff == dtdec_pkg::DTDEC_FETCH && have_bytes && NARROW_BUS && WORD_OP_I &&
        head0 == dtdec_pkg::OP_TABLE_LOOKUP |=> clocks_ff == dtdec_pkg::CLK_LOOKUP_N +
        dtdec_pkg::CLK_WORD_PER_XFER)
        else $error("word penalty missing");
endmodule
`default_nettype wire

/* test_data_transfer_decode_timing.sv */
// Bench: wide and narrow variants side by side, each fed by a prefetch model.
// Assumes dtdec_pkg, the design files and dtdec_feeder are compiled first.
`default_nettype none
module test_data_transfer_decode_timing;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, start, slow, word, wt, clr;
    logic [3:0] nb;
    logic [95:0] stream;
    logic valid [2];
    logic ready [2];
    logic busy [2];
    logic done [2];
    logic ill [2];
    logic low_seen [2];
    logic [7:0] fbyte [2];
    logic [7:0] modrm [2];
    logic [3:0] op [2];
    logic [5:0] clocks [2];
    int bcnt [2];
    int len [2];
    int dones [2];
    int shakes [2];
    int err_count;
    int cmp_count;
    for (genvar g = 0; g < 2; g++) begin : v
        dtdec_feeder u_feed (.clk_i(clk), .start_i(start), .nbytes_i(nb), .bytes_i(stream),
            .slow_i(slow), .ready_i(ready[g]), .valid_o(valid[g]), .byte_o(fbyte[g]));
        dtdec_top #(.NARROW_BUS(1'(g))) DUT (.CORE_CLK_I(clk), .NRST_I(nrst),
            .FETCH_VALID_I(valid[g]), .FETCH_BYTE_I(fbyte[g]), .FETCH_READY_O(ready[g]),
            .WORD_OP_I(word), .MEM_WAIT_I(wt), .OP_O(op[g]), .BUSY_O(busy[g]),
            .DONE_O(done[g]), .ILLEGAL_O(ill[g]), .MODRM_O(modrm[g]), .CLOCKS_O(clocks[g]));
        // Busy length of the last instruction, latched at its done pulse
        always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                bcnt[g] <= 0;
                len[g] <= 0;
                dones[g] <= 0;
            end else if (done[g]) begin
                len[g] <= bcnt[g];
                bcnt[g] <= 0;
                dones[g] <= dones[g] + 1;
            end else if (busy[g]) begin
                bcnt[g] <= bcnt[g] + 1;
            end
        end
        // Handshakes taken before the queue first refuses
        always @(posedge clk) begin
            if (clr) begin
                shakes[g] <= 0;
                low_seen[g] <= 1'b0;
            end else if (valid[g] && !low_seen[g]) begin
                shakes[g] <= shakes[g] + int'(ready[g]);
                low_seen[g] <= !ready[g];
            end
        end
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Opcode in the low byte; waits for nd done pulses on both variants
    task automatic run(input logic [95:0] b, input int n, input logic w, input logic m,
                       input int nd);
        int s0;
        int s1;
        int k;
        s0 = dones[0];
        s1 = dones[1];
        stream = b;
        nb = 4'(n);
        word = w;
        wt = m;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        k = 0;
        while ((dones[0] < s0 + nd || dones[1] < s1 + nd) && k < 600) begin
            @(negedge clk);
            k++;
        end
        if (k >= 600) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, dones[0], s0 + nd);
            wrap_up();
        end
    endtask
    task automatic expect2(input logic [3:0] eop, input logic eill, input logic [7:0] em,
                           input int ew, input int en, input int slack);
        int e;
        for (int g = 0; g < 2; g++) begin
            e = (g == 0) ? ew : en;
            cmp(32'(ill[g]), 32'(eill));
            if (slack == 0) begin
                cmp(len[g], e);
            end else begin
                cmp(32'(len[g] >= e && len[g] <= e + slack), 32'h0000_0001);
            end
            if (!eill) begin
                cmp(32'(op[g]), 32'(eop));
                cmp(32'(modrm[g]), 32'(em));
                cmp(32'(clocks[g]), e);
            end
        end
    endtask
    task automatic test_seg_moves();
        run(96'hC08E, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_SEG_LOAD, 1'b0, 8'hC0, 2, 2, 0);
        run(96'h1E8E, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_SEG_LOAD, 1'b0, 8'h1E, 9, 13, 0);
        run(96'hD88C, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_SEG_STORE, 1'b0, 8'hD8, 2, 2, 0);
        run(96'h868C, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_SEG_STORE, 1'b0, 8'h86, 11, 15, 0);
        $display("test_seg_moves done");
    endtask
    task automatic test_lookup_word();
        run(96'h00D7, 1, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_TABLE_LOOKUP, 1'b0, 8'h00, 11, 15, 0);
        run(96'h00D7, 1, 1'b1, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_TABLE_LOOKUP, 1'b0, 8'h00, 11, 19, 0);
        run(96'h0E8E, 2, 1'b1, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_SEG_LOAD, 1'b0, 8'h0E, 9, 13, 0);
        $display("test_lookup_word done");
    endtask
    task automatic test_ea_far();
        run(96'h468D, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_EA_LOAD, 1'b0, 8'h46, 6, 6, 0);
        run(96'h16C5, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_FAR_DATA_SEG, 1'b0, 8'h16, 18, 26, 0);
        run(96'h96C4, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_FAR_EXTRA_SEG, 1'b0, 8'h96, 18, 26, 0);
        $display("test_ea_far done");
    endtask
    task automatic test_illegal();
        run(96'hC3C5, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_NONE, 1'b1, 8'h00, 0, 0, 0);
        run(96'hD8C4, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_NONE, 1'b1, 8'h00, 0, 0, 0);
        run(96'h0090, 1, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_NONE, 1'b1, 8'h00, 0, 0, 0);
        cmp(32'(op[0]), 32'(dtdec_pkg::DTDEC_NONE));
        run(96'h9ED8C4, 3, 1'b0, 1'b0, 2);
        expect2(dtdec_pkg::DTDEC_ACC_TO_FLAGS, 1'b0, 8'h00, 3, 3, 0);
        $display("test_illegal done");
    endtask
    task automatic test_flags_b2b();
        run(96'h9E9F_9E9F, 4, 1'b0, 1'b0, 4);
        expect2(dtdec_pkg::DTDEC_ACC_TO_FLAGS, 1'b0, 8'h00, 3, 3, 0);
        run(96'h009F, 1, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_FLAGS_TO_ACC, 1'b0, 8'h00, 2, 2, 0);
        $display("test_flags_b2b done");
    endtask
    task automatic test_wait();
        run(96'h068C, 2, 1'b0, 1'b1, 1);
        expect2(dtdec_pkg::DTDEC_SEG_STORE, 1'b0, 8'h06, 11, 15, 2);
        run(96'h00D7, 1, 1'b0, 1'b1, 1);
        expect2(dtdec_pkg::DTDEC_TABLE_LOOKUP, 1'b0, 8'h00, 11, 15, 2);
        run(96'hC08E, 2, 1'b0, 1'b1, 1);
        expect2(dtdec_pkg::DTDEC_SEG_LOAD, 1'b0, 8'hC0, 2, 2, 0);
        $display("test_wait done");
    endtask
    task automatic test_slow();
        slow = 1'b1;
        run(96'h1E8E, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_SEG_LOAD, 1'b0, 8'h1E, 9, 13, 0);
        run(96'h06C4, 2, 1'b0, 1'b0, 1);
        expect2(dtdec_pkg::DTDEC_FAR_EXTRA_SEG, 1'b0, 8'h06, 18, 26, 0);
        slow = 1'b0;
        $display("test_slow done");
    endtask
    // Long far load keeps the queue undrained while the model keeps offering
    task automatic test_fill();
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        run(96'h9F9F_9F9F_9F9F_9F9F_9F9F_06C5, 12, 1'b0, 1'b0, 5);
        cmp(32'(low_seen[0]), 32'h0000_0001);
        cmp(32'(low_seen[1]), 32'h0000_0001);
        cmp(32'(shakes[0] >= 8 && shakes[0] <= 9), 32'h0000_0001);
        cmp(32'(shakes[1] >= 6 && shakes[1] <= 7), 32'h0000_0001);
        repeat (100) @(negedge clk);
        cmp(32'(busy[0] | busy[1]), 32'h0000_0000);
        $display("test_fill done");
    endtask
    initial begin
        err_count = 0;
        cmp_count = 0;
        nrst = 1'b0;
        start = 1'b0;
        slow = 1'b0;
        word = 1'b0;
        wt = 1'b0;
        clr = 1'b0;
        nb = 4'h0;
        stream = 96'h0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        test_seg_moves();
        test_lookup_word();
        test_ea_far();
        test_illegal();
        test_flags_b2b();
        test_wait();
        test_slow();
        test_fill();
        wrap_up();
    end
endmodule
`default_nettype wire
